// *** atx_pkg.sv ***
// Purpose: shared constants and types of the transmitter configuration block
// Assumes: 200 MHz core clock for shaping units, 16 MHz reference crystal for deviations
// Notes: register offsets address byte-wide configuration registers
package atx_pkg;
    // =========================================================
    // register map
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PWR = 4'h1;
    localparam logic [3:0] ADDR_CAP = 4'h2;
    localparam logic [3:0] ADDR_STEP = 4'h3;
    localparam logic [3:0] ADDR_IVL = 4'h4;
    localparam logic [3:0] ADDR_FCE_LO = 4'h5;
    localparam logic [3:0] ADDR_FCE_HI = 4'h6;
    localparam logic [3:0] ADDR_FHI_LO = 4'h7;
    localparam logic [3:0] ADDR_FHI_HI = 4'h8;
    localparam logic [3:0] ADDR_FLO_LO = 4'h9;
    localparam logic [3:0] ADDR_FLO_HI = 4'ha;
    localparam logic [3:0] ADDR_STAT = 4'hb;
    // control register fields
    localparam int CTRL_FSK = 0;
    localparam int CTRL_BW = 1;
    localparam int CTRL_SHP_LSB = 2;
    localparam int CTRL_DSHAPE = 4;
    // =========================================================
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [4:0] PWR_RST = 5'h1e;
    localparam logic [4:0] CAP_RST = 5'h00;
    localparam logic [4:0] STEP_RST = 5'h01;
    localparam logic [7:0] IVL_RST = 8'h01;
    localparam logic [15:0] DIV_RST = 16'h7000;
    // =========================================================
    // divide ratio word: top nibble is ratio minus 16, 12 fraction bits
    localparam logic [15:0] DIV_MIN = 16'h3000;
    localparam logic [15:0] DIV_MAX = 16'hc000;
    localparam logic [4:0] PWR_MAX = 5'h1e;
    localparam logic [1:0] SHP_MAX = 2'h2;
    localparam logic [1:0] SHP_MANUAL = 2'h1;
    // manual deviations in 1/4096 crystal steps (16 MHz crystal)
    localparam logic [15:0] DEV_SMALL = 16'h0004;
    localparam logic [15:0] DEV_LARGE = 16'h000d;
    // manual tuning capacitor presets picked by the data pin
    localparam logic [4:0] MAN_CAP_LO = 5'h08;
    localparam logic [4:0] MAN_CAP_HI = 5'h18;
    // =========================================================
    // shaping step unit: 0.25 us rounded up to core cycles
    localparam int STEP_UNIT_NS = 250;
    localparam int CLK_MHZ = 200;
    localparam int STEP_UNIT_CYC = (STEP_UNIT_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_DEEP = 3'b100
    } atx_state_t;
endpackage : atx_pkg

// *** atx_sync.sv ***
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are asynchronous levels
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module atx_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } atx_sync_st_t;
    atx_sync_st_t s_q, s_d;
    // =========================================================
    // two stages
    always_comb
    begin
        s_d = s_q;
        s_d.meta = d_in;
        s_d.stab = s_q.meta;
    end
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            s_q <= '0;
        else
            s_q <= s_d;
    end
    assign q_out = s_q.stab;
endmodule : atx_sync

// *** atx_shaper.sv ***
// Purpose: digital ask envelope ramp in power-code steps
// Assumes: one power code is roughly 1 dB
// Notes: interval counts in 0.25 us units, zero acts as one
`timescale 1ns/1ps
module atx_shaper (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic on_in,
    input wire logic key_in,
    input wire logic [4:0] target_in,
    input wire logic [4:0] step_in,
    input wire logic [7:0] ivl_in,
    output logic [4:0] level_out
);
    typedef struct packed {
        logic [4:0] level;
        logic [5:0] unit;
        logic [7:0] ivl;
    } atx_shp_st_t;
    atx_shp_st_t s_q, s_d;
    logic [5:0] level_sum;
    logic [4:0] step_eff;
    // =========================================================
    // ramp toward target when keyed, toward zero otherwise
    always_comb
    begin
        s_d = s_q;
        // a zero step would stall the ramp in both directions, so it acts as one
        step_eff = (step_in == 5'h00) ? 5'h01 : step_in;
        level_sum = {1'b0, s_q.level} + {1'b0, step_eff};
        if (!on_in)
        begin
            s_d = '0;
            s_d.level = key_in ? target_in : 5'h00;
        end
        else if (s_q.unit != 6'(atx_pkg::STEP_UNIT_CYC - 1))
            s_d.unit = s_q.unit + 6'h01;
        else
        begin
            s_d.unit = 6'h00;
            if (s_q.ivl + 8'h01 < ivl_in)
                s_d.ivl = s_q.ivl + 8'h01;
            else
            begin
                s_d.ivl = 8'h00;
                if (key_in)
                    s_d.level = (level_sum > {1'b0, target_in}) ? target_in : level_sum[4:0];
                else
                    s_d.level = (s_q.level > step_eff) ? s_q.level - step_eff : 5'h00;
            end
        end
    end
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            s_q <= '0;
        else
            s_q <= s_d;
    end
    assign level_out = s_q.level;
endmodule : atx_shaper

// *** atx_core.sv ***
// Purpose: configuration and modulation control of an ask/fsk transmitter
// Assumes: all pins are asynchronous; register port on the core clock
// Notes: registers are lost in deep shutdown and must be rewritten
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - enable low, shutdown select high, 3V supply: everything off including reset circuit
// - with 5V supply deep shutdown never happens; select held at ground
// - divide ratio accepted from 19 to 28; carrier is crystal times ratio
// - divide word is 16 bits: 4 integer, 12 fraction
// - tuning capacitor code 0..31, 0.25pF per code
// - capacitor code from register, or from data pin in manual mode
// - register mode offers 31 power settings of about 1 dB
// - manual mode gives four power levels from two power pins
// - manual deviation is small or large, chosen by a pin
// - register mode deviation fully programmable via mark and space words
// - digital shaping ramps power in programmable steps and intervals
// - analog shaping: three times by register, one fixed in manual
// - loop bandwidth choice only through registers
// - ask uses the 16-bit center word from two byte registers
// - fsk uses mark and space words, switched by data
// - manual divide ratio is a preset chosen by three select pins
// - modulator follows nrz data up to 100/140 kbps
// - all three select pins low means register mode, else manual
// - manual modulation pin: low ask, high fsk
// - manual chip-select pin: low small deviation, high large
// - enable rise turns circuits on; pa waits for data in ask
module atx_core (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic freq_select_bit0_in,
    input wire logic freq_select_bit1_in,
    input wire logic freq_select_bit2_in,
    input wire logic chip_select_or_deviation_in,
    input wire logic aux_out_or_modulation_select_in,
    input wire logic serial_in_or_power_msb_in,
    input wire logic serial_clock_or_power_lsb_in,
    input wire logic enable_in,
    input wire logic deep_shutdown_select_in,
    input wire logic tx_data_in,
    input wire logic supply_5v_in,
    output logic [15:0] divide_ratio_out,
    output logic [4:0] pa_power_code_out,
    output logic [4:0] tune_cap_code_out,
    output logic [1:0] analog_shape_time_out,
    output logic loop_bw_wide_out,
    output logic pa_on_out,
    output logic circuits_on_out,
    output logic deep_shutdown_out,
    output logic manual_mode_out,
    output logic fsk_mode_out
);
    typedef struct packed {
        atx_pkg::atx_state_t state;
        logic en;
        logic [7:0] ctrl;
        logic [4:0] pwr;
        logic [4:0] cap;
        logic [4:0] step;
        logic [7:0] ivl;
        logic [15:0] fce;
        logic [15:0] fhi;
        logic [15:0] flo;
        logic [4:0] man_cap;
        logic [7:0] rdata;
        logic [15:0] div;
        logic [4:0] pwr_out;
        logic [4:0] cap_out;
        logic [1:0] shp;
        logic bw;
        logic pa_on;
        logic fsk;
    } atx_core_st_t;

    localparam atx_core_st_t ST_RST = '{
        state: atx_pkg::ST_IDLE, en: 1'b0, ctrl: atx_pkg::CTRL_RST,
        pwr: atx_pkg::PWR_RST, cap: atx_pkg::CAP_RST, step: atx_pkg::STEP_RST,
        ivl: atx_pkg::IVL_RST, fce: atx_pkg::DIV_RST, fhi: atx_pkg::DIV_RST,
        flo: atx_pkg::DIV_RST, man_cap: atx_pkg::MAN_CAP_LO, rdata: 8'h00,
        div: atx_pkg::DIV_RST, pwr_out: 5'h00, cap_out: atx_pkg::CAP_RST,
        shp: 2'h0, bw: 1'b0, pa_on: 1'b0, fsk: 1'b0};

    atx_core_st_t s_q, s_d;
    logic [10:0] pins;
    logic [2:0] fsel;
    logic dev_s, mod_s, p1_s, p0_s, en_s, deep_shutdown_select_s, din_s, v5_s;
    logic manual, deep_req, en_rise, ask_shape, fsk_now;
    logic [4:0] shp_level;
    logic [15:0] man_base, man_dev, mark_w, space_w;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    // =========================================================
    // helpers
    // keep the word inside 19.0 .. 28.0
    function automatic logic [15:0] clamp_div(input logic [15:0] w);
        if (w < atx_pkg::DIV_MIN)
            return atx_pkg::DIV_MIN;
        else if (w > atx_pkg::DIV_MAX)
            return atx_pkg::DIV_MAX;
        else
            return w;
    endfunction : clamp_div

    // preset ratios for the manual select codes
    function automatic logic [15:0] man_div(input logic [2:0] c);
        return {4'(4'h3 + {1'b0, c}), 12'h800};
    endfunction : man_div

    // four fixed manual power levels
    function automatic logic [4:0] man_pwr(input logic [1:0] c);
        return 5'(10 * c);
    endfunction : man_pwr

    // =========================================================
    // pin synchronisers: every pin is asynchronous to the core
    atx_sync #(
        .W(11)
    ) u_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .d_in({freq_select_bit2_in, freq_select_bit1_in, freq_select_bit0_in,
               chip_select_or_deviation_in, aux_out_or_modulation_select_in,
               serial_in_or_power_msb_in, serial_clock_or_power_lsb_in,
               enable_in, deep_shutdown_select_in, tx_data_in, supply_5v_in}),
        .q_out(pins)
    );
    assign {fsel, dev_s, mod_s, p1_s, p0_s, en_s, deep_shutdown_select_s, din_s, v5_s} = pins;

    // =========================================================
    // mode decode
    assign manual = (fsel != 3'h0);
    assign deep_req = !en_s && deep_shutdown_select_s && !v5_s;
    assign en_rise = en_s && !s_q.en;
    assign fsk_now = manual ? mod_s : s_q.ctrl[atx_pkg::CTRL_FSK];
    assign ask_shape = !manual && !fsk_now && s_q.ctrl[atx_pkg::CTRL_DSHAPE];
    assign man_base = man_div(fsel);
    assign man_dev = dev_s ? atx_pkg::DEV_LARGE : atx_pkg::DEV_SMALL;
    // manual mark and space sit symmetric about the preset
    assign mark_w = manual ? clamp_div(man_base + man_dev) : clamp_div(s_q.fhi);
    assign space_w = manual ? clamp_div(man_base - man_dev) : clamp_div(s_q.flo);

    // =========================================================
    // digital envelope shaping, ask in register mode only
    atx_shaper u_shaper (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .on_in(ask_shape && (s_q.state == atx_pkg::ST_ACTIVE)),
        .key_in(din_s),
        .target_in(s_q.pwr),
        .step_in(s_q.step),
        .ivl_in(s_q.ivl),
        .level_out(shp_level)
    );

    // =========================================================
    // next state: power fsm, register port, output selection
    always_comb
    begin
        s_d = s_q;
        s_d.en = en_s;
        s_d.rdata = 8'h00;
        unique case (s_q.state)
            atx_pkg::ST_IDLE:
            begin
                if (deep_req)
                    s_d.state = atx_pkg::ST_DEEP;
                else if (en_rise)
                    s_d.state = atx_pkg::ST_ACTIVE;
            end
            atx_pkg::ST_ACTIVE:
            begin
                if (!en_s)
                    s_d.state = deep_req ? atx_pkg::ST_DEEP : atx_pkg::ST_IDLE;
            end
            atx_pkg::ST_DEEP:
            begin
                if (en_rise)
                    s_d.state = atx_pkg::ST_ACTIVE;
                else if (!deep_req)
                    s_d.state = atx_pkg::ST_IDLE;
            end
            default:
                s_d.state = atx_pkg::ST_IDLE;
        endcase
        // manual capacitor preset caught from the data pin at enable rise
        if (en_rise && manual)
            s_d.man_cap = din_s ? atx_pkg::MAN_CAP_HI : atx_pkg::MAN_CAP_LO;
        // writes only in register mode; the serial pins are straps otherwise
        if (wr_in && !manual && s_q.state != atx_pkg::ST_DEEP)
        begin
            unique case (addr_in)
                atx_pkg::ADDR_CTRL: s_d.ctrl = wdata_in;
                atx_pkg::ADDR_PWR: s_d.pwr = (wdata_in[4:0] > atx_pkg::PWR_MAX) ?
                    atx_pkg::PWR_MAX : wdata_in[4:0];
                atx_pkg::ADDR_CAP: s_d.cap = wdata_in[4:0];
                atx_pkg::ADDR_STEP: s_d.step = wdata_in[4:0];
                atx_pkg::ADDR_IVL: s_d.ivl = wdata_in;
                atx_pkg::ADDR_FCE_LO: s_d.fce[7:0] = wdata_in;
                atx_pkg::ADDR_FCE_HI: s_d.fce[15:8] = wdata_in;
                atx_pkg::ADDR_FHI_LO: s_d.fhi[7:0] = wdata_in;
                atx_pkg::ADDR_FHI_HI: s_d.fhi[15:8] = wdata_in;
                atx_pkg::ADDR_FLO_LO: s_d.flo[7:0] = wdata_in;
                atx_pkg::ADDR_FLO_HI: s_d.flo[15:8] = wdata_in;
                default: ;
            endcase
        end
        // reads answer in the next cycle; unmapped reads give zero
        if (rd_in)
        begin
            unique case (addr_in)
                atx_pkg::ADDR_CTRL: s_d.rdata = s_q.ctrl;
                atx_pkg::ADDR_PWR: s_d.rdata = {3'h0, s_q.pwr};
                atx_pkg::ADDR_CAP: s_d.rdata = {3'h0, s_q.cap};
                atx_pkg::ADDR_STEP: s_d.rdata = {3'h0, s_q.step};
                atx_pkg::ADDR_IVL: s_d.rdata = s_q.ivl;
                atx_pkg::ADDR_FCE_LO: s_d.rdata = s_q.fce[7:0];
                atx_pkg::ADDR_FCE_HI: s_d.rdata = s_q.fce[15:8];
                atx_pkg::ADDR_FHI_LO: s_d.rdata = s_q.fhi[7:0];
                atx_pkg::ADDR_FHI_HI: s_d.rdata = s_q.fhi[15:8];
                atx_pkg::ADDR_FLO_LO: s_d.rdata = s_q.flo[7:0];
                atx_pkg::ADDR_FLO_HI: s_d.rdata = s_q.flo[15:8];
                atx_pkg::ADDR_STAT: s_d.rdata = {2'h0, s_q.pa_on, s_q.fsk, manual,
                    s_q.state == atx_pkg::ST_DEEP, s_q.state == atx_pkg::ST_ACTIVE, s_q.en};
                default: s_d.rdata = 8'h00;
            endcase
        end
        // synthesizer word: center for ask, mark/space by data for fsk
        s_d.fsk = fsk_now;
        if (fsk_now)
            s_d.div = din_s ? mark_w : space_w;
        else
            s_d.div = manual ? clamp_div(man_base) : clamp_div(s_q.fce);
        s_d.cap_out = manual ? s_q.man_cap : s_q.cap;
        s_d.bw = manual ? 1'b0 : s_q.ctrl[atx_pkg::CTRL_BW];
        // analog ramp time: codes above the last legal one saturate
        if (manual)
            s_d.shp = atx_pkg::SHP_MANUAL;
        else if (s_q.ctrl[atx_pkg::CTRL_SHP_LSB +: 2] > atx_pkg::SHP_MAX)
            s_d.shp = atx_pkg::SHP_MAX;
        else
            s_d.shp = s_q.ctrl[atx_pkg::CTRL_SHP_LSB +: 2];
        // pa: off unless active, then on in fsk, follows data in ask, ramps when shaping
        if (s_q.state != atx_pkg::ST_ACTIVE)
            s_d.pa_on = 1'b0;
        else if (fsk_now)
            s_d.pa_on = 1'b1;
        else if (ask_shape)
            s_d.pa_on = din_s || (shp_level != 5'h00);
        else
            s_d.pa_on = din_s;
        if (manual)
            s_d.pwr_out = man_pwr({p1_s, p0_s});
        else if (ask_shape)
            s_d.pwr_out = shp_level;
        else
            s_d.pwr_out = s_q.pwr;
        // deep shutdown drops every register but state and en back to reset
        if (s_d.state == atx_pkg::ST_DEEP)
        begin
            s_d = ST_RST;
            s_d.state = atx_pkg::ST_DEEP;
            s_d.en = en_s;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            s_q <= ST_RST;
        else
            s_q <= s_d;
    end

    // =========================================================
    // outputs from flip-flops, with the state flags and the manual flag decoded from them
    assign rdata_out = s_q.rdata;
    assign divide_ratio_out = s_q.div;
    assign pa_power_code_out = s_q.pwr_out;
    assign tune_cap_code_out = s_q.cap_out;
    assign analog_shape_time_out = s_q.shp;
    assign loop_bw_wide_out = s_q.bw;
    assign pa_on_out = s_q.pa_on;
    assign fsk_mode_out = s_q.fsk;
    assign circuits_on_out = (s_q.state == atx_pkg::ST_ACTIVE);
    assign deep_shutdown_out = (s_q.state == atx_pkg::ST_DEEP);
    assign manual_mode_out = manual;

    // =========================================================
    // checks
    sequence seq_en_rise;
        !en_s ##1 en_s;
    endsequence
    chk_deep_entry: assert property (@(posedge clk_in) disable iff (!nrst_in)
        deep_req && !en_rise |=> deep_shutdown_out)
        else $error("deep shutdown not entered");
    chk_deep_5v: assert property (@(posedge clk_in) disable iff (!nrst_in)
        v5_s |=> !deep_shutdown_out)
        else $error("deep shutdown with 5V supply");
    chk_deep_lost: assert property (@(posedge clk_in) disable iff (!nrst_in)
        deep_shutdown_out |-> s_q.ctrl == atx_pkg::CTRL_RST && s_q.fce == atx_pkg::DIV_RST)
        else $error("registers kept in deep shutdown");
    chk_div_range: assert property (@(posedge clk_in) disable iff (!nrst_in)
        divide_ratio_out >= atx_pkg::DIV_MIN && divide_ratio_out <= atx_pkg::DIV_MAX)
        else $error("divide ratio out of range");
    chk_fsk_mark: assert property (@(posedge clk_in) disable iff (!nrst_in)
        fsk_now && !deep_req |=> divide_ratio_out == ($past(din_s) ? $past(mark_w) : $past(space_w)))
        else $error("fsk word does not follow data");
    chk_man_power: assert property (@(posedge clk_in) disable iff (!nrst_in)
        manual && !deep_req |=> pa_power_code_out == 5'(10 * $past({p1_s, p0_s})))
        else $error("manual power level wrong");
    chk_enable_on: assert property (@(posedge clk_in) disable iff (!nrst_in)
        seq_en_rise |=> circuits_on_out ##1 (circuits_on_out == $past(en_s)))
        else $error("enable rise did not switch on");
    chk_ask_pa: assert property (@(posedge clk_in) disable iff (!nrst_in)
        circuits_on_out && !fsk_now && !ask_shape && en_s |=> pa_on_out == $past(din_s))
        else $error("ask pa not following data");
    chk_cap_src: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !deep_req |=> tune_cap_code_out == ($past(manual) ? $past(s_q.man_cap) : $past(s_q.cap)))
        else $error("capacitor source wrong");
    // fixed settings of manual mode, analog ramp range, the shaped envelope and pa off while circuits are off
    chk_shape_power: assert property (
        ask_shape && !deep_req |=> pa_power_code_out == $past(shp_level))
        else $error("shaped power off the ramp");
    chk_man_bw: assert property (manual && !deep_req |=> !loop_bw_wide_out)
        else $error("loop bandwidth not fixed in manual mode");
    chk_man_shape: assert property (
        manual && !deep_req |=> analog_shape_time_out == atx_pkg::SHP_MANUAL)
        else $error("manual ramp time wrong");
    chk_shape_range: assert property (analog_shape_time_out <= atx_pkg::SHP_MAX)
        else $error("ramp time code out of range");
    chk_man_dev: assert property (
        manual && fsk_now && !deep_req |=> divide_ratio_out == ($past(din_s) ?
            $past(man_base) + $past(man_dev) : $past(man_base) - $past(man_dev)))
        else $error("manual deviation wrong");
    chk_pa_idle: assert property (!circuits_on_out |=> !pa_on_out)
        else $error("pa on while circuits off");
endmodule : atx_core

// *** atx_host.sv ***
// Purpose: host controller model driving the mode pins and data pin
// Assumes: bench gives wanted pin levels as one vector
// Notes: levels move just after a rising edge, like port writes
`timescale 1ns/1ps
module atx_host (
    input wire logic clk_in,
    input wire logic [9:0] want_in,
    output logic [2:0] fsel_out,
    output logic dev_out,
    output logic mod_out,
    output logic [1:0] pwr_out,
    output logic enable_out,
    output logic deep_out,
    output logic data_out
);
    // ==========================================
    // pin driver
    // all-zero select keeps register mode; any other value is manual
    initial
    begin
        {fsel_out, dev_out, mod_out, pwr_out, enable_out, deep_out, data_out} = 10'h000;
    end
    always @(posedge clk_in)
    begin
        {fsel_out, dev_out, mod_out, pwr_out, enable_out} <= want_in[9:2];
        deep_out <= want_in[1];
        data_out <= want_in[0];
    end
endmodule : atx_host

// *** atx_core_bench.sv ***
// Purpose: self-checking bench of the transmitter configuration block
// Assumes: pins settle within five edges of a host change
// Notes: deep shutdown is entered on purpose to see contents lost
`timescale 1ns/1ps
module atx_core_bench;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic supply_5v_in = 1'b0;
    logic [9:0] want = 10'h000;
    logic [7:0] rdata_out;
    logic [15:0] divide_ratio_out;
    logic [4:0] pa_power_code_out, tune_cap_code_out;
    logic [1:0] analog_shape_time_out, pw;
    logic [2:0] fs;
    logic loop_bw_wide_out, pa_on_out, circuits_on_out, deep_shutdown_out;
    logic manual_mode_out, fsk_mode_out, dv, md, en, dp, dt;
    int n_mismatch = 0;
    int tests_run = 0;
    // ==========================================
    // clock and parts
    initial
    begin
        forever #2.5 clk_in = ~clk_in;
    end
    atx_host host (.clk_in, .want_in(want), .fsel_out(fs), .dev_out(dv), .mod_out(md),
        .pwr_out(pw), .enable_out(en), .deep_out(dp), .data_out(dt));
    atx_core dut (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .freq_select_bit0_in(fs[0]), .freq_select_bit1_in(fs[1]), .freq_select_bit2_in(fs[2]),
        .chip_select_or_deviation_in(dv), .aux_out_or_modulation_select_in(md),
        .serial_in_or_power_msb_in(pw[1]), .serial_clock_or_power_lsb_in(pw[0]),
        .enable_in(en), .deep_shutdown_select_in(dp), .tx_data_in(dt), .supply_5v_in,
        .divide_ratio_out, .pa_power_code_out, .tune_cap_code_out, .analog_shape_time_out,
        .loop_bw_wide_out, .pa_on_out, .circuits_on_out, .deep_shutdown_out,
        .manual_mode_out, .fsk_mode_out);
    // ==========================================
    // shared tasks
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr_reg
    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        {addr_in, rd_in} <= {a, 1'b1};
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk("rdata", {8'h00, exp}, {8'h00, rdata_out});
    endtask : rd_reg
    // host change, then a bounded wait for the pin path to settle
    task automatic pins(input logic [9:0] v);
        @(posedge clk_in);
        want <= v;
        repeat (5) @(posedge clk_in);
        #1;
    endtask : pins
    task automatic wait_on();
        int k;
        k = 0;
        while (circuits_on_out !== 1'b1 && k < 10)
        begin
            @(posedge clk_in);
            k++;
        end
        if (circuits_on_out !== 1'b1)
        begin
            n_mismatch++;
            summarize();
        end
    endtask : wait_on
    // ==========================================
    // main sequence
    initial
    begin
        repeat (20) @(posedge clk_in);
        nrst_in <= 1'b1;
        #1 chk("divide", 16'h7000, divide_ratio_out);
        rd_reg(4'h1, 8'h1e);
        rd_reg(4'h3, 8'h01);
        rd_reg(4'hc, 8'h00);
        $display("test reset done");
        // register mode: values past the top are held at the top
        wr_reg(4'h1, 8'h1f);
        rd_reg(4'h1, 8'h1e);
        wr_reg(4'h1, 8'h05);
        wr_reg(4'h2, 8'h1f);
        wr_reg(4'h0, 8'h0a);
        wr_reg(4'h5, 8'h00);
        wr_reg(4'h6, 8'h30);
        wr_reg(4'h7, 8'h23);
        wr_reg(4'h8, 8'h51);
        wr_reg(4'h9, 8'h00);
        wr_reg(4'ha, 8'h4f);
        pins(10'b000_0_0_00_1_0_1);
        wait_on();
        chk("divide", 16'h3000, divide_ratio_out);
        chk("cap", 16'h1f, tune_cap_code_out);
        chk("bw", 16'h1, loop_bw_wide_out);
        chk("shape", 16'h2, analog_shape_time_out);
        chk("power", 16'h05, pa_power_code_out);
        chk("pa_on", 16'h1, pa_on_out);
        pins(10'b000_0_0_00_1_0_0);
        chk("pa_on", 16'h0, pa_on_out);
        wr_reg(4'h6, 8'hd0);
        pins(10'b000_0_0_00_1_0_0);
        chk("divide", 16'hc000, divide_ratio_out);
        $display("test register ask done");
        wr_reg(4'h0, 8'h01);
        pins(10'b000_0_0_00_1_0_1);
        chk("divide", 16'h5123, divide_ratio_out);
        chk("fsk", 16'h1, fsk_mode_out);
        pins(10'b000_0_0_00_1_0_0);
        chk("divide", 16'h4f00, divide_ratio_out);
        $display("test register fsk done");
        // digital shaping: step 2 every 50 cycles up to the target of 5, then down
        wr_reg(4'h3, 8'h02);
        wr_reg(4'h0, 8'h10);
        pins(10'b000_0_0_00_1_0_1);
        chk("pa_on", 16'h1, pa_on_out);
        for (int i = 0; i < 4; i++)
        begin
            repeat (i > 0 ? 50 : 0) @(posedge clk_in);
            #1 chk("ramp", 16'(i == 3 ? 5 : 2 * i), pa_power_code_out);
        end
        rd_reg(4'hb, 8'h23);
        pins(10'b000_0_0_00_1_0_0);
        chk("pa_on", 16'h1, pa_on_out);
        repeat (150) @(posedge clk_in);
        #1 chk("ramp", 16'h0, pa_power_code_out);
        chk("pa_on", 16'h0, pa_on_out);
        $display("test shaping done");
        // manual: select 1, fsk, large deviation, cap taken at enable rise
        pins(10'b001_1_1_11_0_0_1);
        chk("manual", 16'h1, manual_mode_out);
        chk("on", 16'h0, circuits_on_out);
        pins(10'b001_1_1_11_1_0_1);
        chk("cap", 16'h18, tune_cap_code_out);
        chk("divide", 16'h480d, divide_ratio_out);
        chk("shape", 16'h1, analog_shape_time_out);
        chk("bw", 16'h0, loop_bw_wide_out);
        pins(10'b001_0_1_11_1_0_0);
        chk("divide", 16'h47fc, divide_ratio_out);
        for (int i = 0; i < 4; i++)
        begin
            pins({3'b001, 2'b11, 2'(i), 3'b101});
            chk("power", 16'(10 * i), pa_power_code_out);
        end
        wr_reg(4'h1, 8'h03);
        rd_reg(4'h1, 8'h05);
        pins(10'b001_0_0_00_1_0_1);
        chk("divide", 16'h4800, divide_ratio_out);
        $display("test manual done");
        // deep shutdown loses every register; 5V strap refuses it
        pins(10'b000_0_0_00_0_1_0);
        chk("deep", 16'h1, deep_shutdown_out);
        pins(10'b000_0_0_00_0_0_0);
        rd_reg(4'h0, 8'h00);
        rd_reg(4'h1, 8'h1e);
        wr_reg(4'h0, 8'h02);
        rd_reg(4'h0, 8'h02);
        @(posedge clk_in);
        supply_5v_in <= 1'b1;
        pins(10'b000_0_0_00_0_1_0);
        chk("deep", 16'h0, deep_shutdown_out);
        $display("test shutdown done");
        summarize();
    end
endmodule : atx_core_bench
